// File: include/cfm_map.vh
// Register map, field positions, reset values and counts of the clock fail monitor
`ifndef CFM_MAP_VH
`define CFM_MAP_VH

`define CFM_ADDR_W        4
`define CFM_DATA_W        8

`define CFM_OFF_CLKSEL    4'h0
`define CFM_OFF_FLAG      4'h1
`define CFM_OFF_MASK      4'h2
`define CFM_OFF_STAT      4'h3

`define CFM_SRC_LSB       0
`define CFM_SRC_MSB       1
`define CFM_PRUN_BIT      3
`define CFM_IFS_LSB       4
`define CFM_IFS_MSB       6
`define CFM_FAIL_BIT      7

`define CFM_STAT_FSAFE    0
`define CFM_STAT_ENA      1
`define CFM_STAT_MON      2
`define CFM_STAT_START    3

`define CFM_SRC_PRIMARY   2'h0
`define CFM_SRC_SECONDARY 2'h1
`define CFM_SRC_INTERNAL  2'h2

`define CFM_CLKSEL_RST    8'h00
`define CFM_MASK_RST      8'h00
`define CFM_IFS_RST       3'h0

`define CFM_DIV_RATIO     64
`define CFM_DIV_W         6

`endif

// File: hw/cfm_edge.v
// Edge detector for an input sampled on the system clock
`timescale 1ns/10ps
module cfm_edge (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire sig_in,
  output reg  rise_q,
  output reg  fall_q
);
  reg last_q;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // Track the pin in reset so no false edge follows release
      last_q <= sig_in;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      last_q <= sig_in;
      rise_q <= sig_in & ~last_q;
      fall_q <= ~sig_in & last_q;
    end
  end
endmodule

// File: hw/cfm_div.v
// Sample clock divider counting low-power RC oscillator edges
`timescale 1ns/10ps
`include "cfm_map.vh"
module cfm_div #(
  parameter RATIO = `CFM_DIV_RATIO,
  parameter W     = `CFM_DIV_W
) (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire run,
  input  wire osc_rise,
  output reg  samp_rise_q,
  output reg  samp_fall_q
);
  localparam integer LAST_I = RATIO - 1;
  localparam integer HALF_I = RATIO / 2 - 1;
  localparam [W-1:0] LAST   = LAST_I[W-1:0];
  localparam [W-1:0] HALF   = HALF_I[W-1:0];
  reg [W-1:0] cnt_q;

  // R03: divide by 64
  always @(posedge sys_clk) begin
    if (sys_rst || !run) begin
      cnt_q       <= {W{1'b0}};
      samp_rise_q <= 1'b0;
      samp_fall_q <= 1'b0;
    end else begin
      samp_rise_q <= osc_rise && (cnt_q == LAST);
      samp_fall_q <= osc_rise && (cnt_q == HALF);
      if (osc_rise) begin
        cnt_q <= (cnt_q == LAST) ? {W{1'b0}} : cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: hw/cfm_top.v
// Fail-safe clock monitor: supervision, source switching, recovery and registers
`timescale 1ns/10ps
`include "cfm_map.vh"
// Function
// R01: Monitor works only with enable fuse set
// R02: RC oscillator runs while monitor enabled
// R03: Sample clock is RC divided by 64
// R04: Latch set by clock fall, cleared by sample
// R05: Sample fall with latch set means failure
// R06: Failure sets fail flag bit seven
// R07: Switch to internal; select register unchanged
// R08: Failure resets watchdog and postscaler
// R09: Only primary and secondary are supervised
// R10: Watchdog disable never stops RC oscillator; code stops it when the fuse is clear
// R11: Fail-safe ends on reset or power-managed entry
// R12: After reset internal clock until primary ready
// R13: Primary ready: switch, set running flag
// R14: Primary never ready: select register keeps reset
// R15: Software sets frequency field before sleep
// R16: Fail flag sticky until software clears it
module cfm_top (
  input  wire                   sys_clk,
  input  wire                   sys_rst,
  input  wire                   monitor_enable_fuse,
  input  wire                   watchdog_enable,
  input  wire                   low_power_rc_osc,
  input  wire                   primary_clk_in,
  input  wire                   secondary_clk_in,
  input  wire                   primary_ready,
  input  wire                   pm_mode_entry,
  input  wire [`CFM_ADDR_W-1:0] reg_addr,
  input  wire [`CFM_DATA_W-1:0] reg_wdata,
  input  wire                   reg_we,
  input  wire                   reg_re,
  output reg  [`CFM_DATA_W-1:0] reg_rdata_q,
  output reg  [1:0]             dev_clk_sel_q,
  output reg                    lprc_run_q,
  output reg                    watchdog_clear_q,
  output reg                    fail_safe_q,
  output reg                    osc_fail_irq_q
);
  localparam [2:0] ST_START = 3'b001;
  localparam [2:0] ST_RUN   = 3'b010;
  localparam [2:0] ST_FAIL  = 3'b100;

  localparam [`CFM_DATA_W-1:0] CLKSEL_RST = `CFM_CLKSEL_RST;
  localparam [`CFM_DATA_W-1:0] MASK_RST   = `CFM_MASK_RST;

  reg  [2:0]             state_q;
  reg  [2:0]             state_d;
  reg                    ena_q;
  reg  [1:0]             src_sel_q;
  reg  [2:0]             freq_sel_q;
  reg                    osc_fail_flag_q;
  reg                    mask_q;
  reg                    edge_seen_latch_q;
  reg                    fail_det;
  reg                    mon_clk;
  reg  [`CFM_DATA_W-1:0] rd_mux;
  wire                   rc_rise;
  wire                   mon_fall;
  wire                   samp_rise;
  wire                   samp_fall;
  wire                   wr_clksel;
  wire                   wr_flag;
  wire                   wr_mask;
  wire                   supervised;
  wire                   monitoring;
  wire                   primary_running_flag;

  function sel_hit;
    input [`CFM_ADDR_W-1:0] a;
    input [`CFM_ADDR_W-1:0] off;
    begin
      sel_hit = (a == off);
    end
  endfunction

  assign wr_clksel = reg_we && sel_hit(reg_addr, `CFM_OFF_CLKSEL);
  assign wr_flag   = reg_we && sel_hit(reg_addr, `CFM_OFF_FLAG);
  assign wr_mask   = reg_we && sel_hit(reg_addr, `CFM_OFF_MASK);

  // Fuse is non-volatile, so a plain resample each cycle is enough
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ena_q <= 1'b0;
    end else begin
      ena_q <= monitor_enable_fuse;
    end
  end

  // R09: internal source never supervised
  assign supervised = (src_sel_q == `CFM_SRC_PRIMARY) || (src_sel_q == `CFM_SRC_SECONDARY);
  // R01: supervision gated by the fuse
  assign monitoring = ena_q && (state_q == ST_RUN) && supervised;

  always @* begin
    mon_clk = 1'b0;
    if (src_sel_q == `CFM_SRC_SECONDARY) begin
      mon_clk = secondary_clk_in;
    end else begin
      mon_clk = primary_clk_in;
    end
  end

  cfm_edge u_rc_edge (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sig_in  (low_power_rc_osc),
    .rise_q  (rc_rise),
    .fall_q  ()
  );

  cfm_edge u_mon_edge (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sig_in  (mon_clk),
    .rise_q  (),
    .fall_q  (mon_fall)
  );

  cfm_div #(
    .RATIO (`CFM_DIV_RATIO),
    .W     (`CFM_DIV_W)
  ) u_div (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .run         (ena_q),
    .osc_rise    (rc_rise),
    .samp_rise_q (samp_rise),
    .samp_fall_q (samp_fall)
  );

  // R04: latch set by clock fall, clear by sample rise; a coincident edge wins
  always @(posedge sys_clk) begin
    if (sys_rst || !monitoring) begin
      edge_seen_latch_q <= 1'b0;
    end else if (mon_fall) begin
      edge_seen_latch_q <= 1'b1;
    end else if (samp_rise) begin
      edge_seen_latch_q <= 1'b0;
    end
  end

  // R05: failure test on sample fall
  always @* begin
    fail_det = monitoring && samp_fall && edge_seen_latch_q;
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_START: begin
        // R13: primary ready ends start-up
        if (primary_ready) begin
          state_d = ST_RUN;
        // R14: select register waits for power-managed entry
        end else if (pm_mode_entry) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // R07: fail-safe entered on failure
        if (fail_det) begin
          state_d = ST_FAIL;
        end
      end
      ST_FAIL: begin
        // R11: only power-managed entry leaves fail-safe here
        if (pm_mode_entry) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_START;
      end
    endcase
  end

  // R12: reset restarts with the internal multiplexer feeding the device
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_START;
    end else begin
      state_q <= state_d;
    end
  end

  // R13: running flag once primary has taken over
  assign primary_running_flag = (state_q == ST_RUN) && (src_sel_q == `CFM_SRC_PRIMARY);

  // R07: select field is left alone on failure
  // R14: writes ignored during start-up so it keeps reset value
  // R15: frequency field is software's to set before sleep
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      src_sel_q  <= CLKSEL_RST[`CFM_SRC_MSB:`CFM_SRC_LSB];
      freq_sel_q <= `CFM_IFS_RST;
    end else if (wr_clksel && (state_q != ST_START)) begin
      src_sel_q  <= reg_wdata[`CFM_SRC_MSB:`CFM_SRC_LSB];
      freq_sel_q <= reg_wdata[`CFM_IFS_MSB:`CFM_IFS_LSB];
    end
  end

  // R06: fail flag set on failure
  // R16: sticky, write one clears, a new failure wins over the clear
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      osc_fail_flag_q <= 1'b0;
    end else if (fail_det) begin
      osc_fail_flag_q <= 1'b1;
    end else if (wr_flag && reg_wdata[`CFM_FAIL_BIT]) begin
      osc_fail_flag_q <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_q <= MASK_RST[`CFM_FAIL_BIT];
    end else if (wr_mask) begin
      mask_q <= reg_wdata[`CFM_FAIL_BIT];
    end
  end

  // Outputs all registered so downstream clock muxing sees clean levels
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      dev_clk_sel_q    <= `CFM_SRC_INTERNAL;
      lprc_run_q       <= 1'b0;
      watchdog_clear_q <= 1'b0;
      fail_safe_q      <= 1'b0;
      osc_fail_irq_q   <= 1'b0;
    end else begin
      // R12: internal source until start-up is over
      // R07: internal source during fail-safe
      if (state_d == ST_RUN) begin
        dev_clk_sel_q <= src_sel_q;
      end else begin
        dev_clk_sel_q <= `CFM_SRC_INTERNAL;
      end
      // R02: oscillator kept running by the monitor
      // R10: watchdog enable also keeps it running, so with the fuse clear a watchdog disable stops it
      lprc_run_q       <= ena_q | watchdog_enable;
      // R08: watchdog and postscaler restart on failure
      watchdog_clear_q <= fail_det;
      fail_safe_q      <= (state_d == ST_FAIL);
      osc_fail_irq_q   <= (osc_fail_flag_q | fail_det) & mask_q;
    end
  end

  always @* begin
    rd_mux = {`CFM_DATA_W{1'b0}};
    case (reg_addr)
      `CFM_OFF_CLKSEL: begin
        rd_mux[`CFM_SRC_MSB:`CFM_SRC_LSB] = src_sel_q;
        rd_mux[`CFM_PRUN_BIT]             = primary_running_flag;
        rd_mux[`CFM_IFS_MSB:`CFM_IFS_LSB] = freq_sel_q;
      end
      `CFM_OFF_FLAG: begin
        rd_mux[`CFM_FAIL_BIT] = osc_fail_flag_q;
      end
      `CFM_OFF_MASK: begin
        rd_mux[`CFM_FAIL_BIT] = mask_q;
      end
      `CFM_OFF_STAT: begin
        rd_mux[`CFM_STAT_FSAFE] = (state_q == ST_FAIL);
        rd_mux[`CFM_STAT_ENA]   = ena_q;
        rd_mux[`CFM_STAT_MON]   = monitoring;
        rd_mux[`CFM_STAT_START] = (state_q == ST_START);
      end
      default: begin
        rd_mux = {`CFM_DATA_W{1'b0}};
      end
    endcase
  end

  // Read data stands one cycle after the strobe only
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata_q <= {`CFM_DATA_W{1'b0}};
    end else if (reg_re) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= {`CFM_DATA_W{1'b0}};
    end
  end
endmodule

// File: tb/cfm_top_chk.sv
// Port-level assertions for the clock fail monitor
`timescale 1ns/10ps
`include "cfm_map.vh"
module cfm_top_chk (
  input wire                   sys_clk,
  input wire                   sys_rst,
  input wire                   monitor_enable_fuse,
  input wire                   watchdog_enable,
  input wire                   low_power_rc_osc,
  input wire                   primary_clk_in,
  input wire                   secondary_clk_in,
  input wire                   primary_ready,
  input wire                   pm_mode_entry,
  input wire [`CFM_ADDR_W-1:0] reg_addr,
  input wire [`CFM_DATA_W-1:0] reg_wdata,
  input wire                   reg_we,
  input wire                   reg_re,
  input wire [`CFM_DATA_W-1:0] reg_rdata_q,
  input wire [1:0]             dev_clk_sel_q,
  input wire                   lprc_run_q,
  input wire                   watchdog_clear_q,
  input wire                   fail_safe_q,
  input wire                   osc_fail_irq_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_WDCLR_FS: assert property ($rose(fail_safe_q) |-> watchdog_clear_q)
    else $error("watchdog not cleared on failure");
  AST_WDCLR_PULSE: assert property (watchdog_clear_q |=> !watchdog_clear_q)
    else $error("watchdog clear longer than one cycle");
  AST_WDCLR_SEL: assert property (watchdog_clear_q |-> fail_safe_q && dev_clk_sel_q == 2'h2)
    else $error("watchdog clear without switch to internal");
  AST_FS_SEL: assert property (fail_safe_q |-> dev_clk_sel_q == 2'h2)
    else $error("fail-safe without internal clock");
  AST_FS_HOLD: assert property (fail_safe_q && !pm_mode_entry |=> fail_safe_q)
    else $error("fail-safe left without cause");
  AST_FS_EXIT: assert property (fail_safe_q && pm_mode_entry |=> !fail_safe_q)
    else $error("fail-safe kept after power-managed entry");
  AST_RST_SEL: assert property ($past(sys_rst) |-> dev_clk_sel_q == 2'h2)
    else $error("device clock not internal after reset");
  AST_NO_FUSE: assert property (!$past(monitor_enable_fuse) && !$past(monitor_enable_fuse, 2)
    |-> !$rose(fail_safe_q))
    else $error("failure declared with monitor disabled");
  AST_LPRC_WD: assert property ($past(watchdog_enable) && !$past(sys_rst) |-> lprc_run_q)
    else $error("rc oscillator stopped with watchdog on");
  AST_LPRC_FUSE: assert property ($past(monitor_enable_fuse, 2) && !$past(sys_rst)
    && !$past(sys_rst, 2) |-> lprc_run_q)
    else $error("rc oscillator stopped with monitor on");
endmodule
bind cfm_top cfm_top_chk u_chk (.sys_clk, .sys_rst, .monitor_enable_fuse, .watchdog_enable,
  .low_power_rc_osc, .primary_clk_in, .secondary_clk_in, .primary_ready, .pm_mode_entry,
  .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata_q, .dev_clk_sel_q, .lprc_run_q,
  .watchdog_clear_q, .fail_safe_q, .osc_fail_irq_q);

// File: tb/cfm_osc_src.sv
// External oscillator model that can be stopped
`timescale 1ns/10ps
module cfm_osc_src #(
  parameter HALF = 10
) (
  input  wire  sys_clk,
  input  wire  run,
  output logic clk_q
);
  int cnt_q;
  initial begin
    clk_q = 1'b0;
    cnt_q = 0;
  end
  // A failed oscillator stands still
  always @(posedge sys_clk) begin
    if (run) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1) clk_q <= ~clk_q;
    end
  end
endmodule

// File: tb/test_cfm_top.sv
// Self-checking bench of the clock fail monitor
`timescale 1ns/10ps
`include "cfm_map.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module test_cfm_top;
  logic sys_clk = 1'b0, sys_rst, monitor_enable_fuse, watchdog_enable, primary_ready;
  logic pm_mode_entry, reg_we, reg_re, p_run;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [1:0] rc_q = 2'h0;
  wire low_power_rc_osc = rc_q[1];
  wire primary_clk_in, secondary_clk_in, lprc_run_q, watchdog_clear_q, fail_safe_q;
  wire osc_fail_irq_q;
  wire [7:0] reg_rdata_q;
  wire [1:0] dev_clk_sel_q;
  int miscompares = 0, n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  // Rc period of four cycles gives a sample period of 256 cycles
  always @(posedge sys_clk) rc_q <= rc_q + 2'h1;
  cfm_osc_src #(.HALF(10)) u_pri (.sys_clk, .run(p_run), .clk_q(primary_clk_in));
  cfm_osc_src #(.HALF(7)) u_sec (.sys_clk, .run(1'b1), .clk_q(secondary_clk_in));
  cfm_top dut (.sys_clk, .sys_rst, .monitor_enable_fuse, .watchdog_enable, .low_power_rc_osc,
    .primary_clk_in, .secondary_clk_in, .primary_ready, .pm_mode_entry, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata_q, .dev_clk_sel_q, .lprc_run_q,
    .watchdog_clear_q, .fail_safe_q, .osc_fail_irq_q);
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task wait_fs(input logic v, input int n);
    for (int i = 0; i < n && fail_safe_q !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (fail_safe_q !== v) begin
      miscompares++;
      $display("[ERR] %0t wait limit on fail-safe", $time);
      complete_run;
    end
  endtask
  task pm_pulse;
    @(posedge sys_clk);
    pm_mode_entry <= 1'b1;
    @(posedge sys_clk);
    pm_mode_entry <= 1'b0;
    #1;
  endtask
  task t_boot;
    logic [7:0] d;
    @(posedge sys_clk);
    wr(`CFM_OFF_CLKSEL, 8'h71);
    rd(`CFM_OFF_CLKSEL, d);
    `CHK(d, `CFM_CLKSEL_RST)
    `CHK(dev_clk_sel_q, `CFM_SRC_INTERNAL)
    rd(`CFM_OFF_STAT, d);
    `CHK(d, 8'h0a)
    rd(4'hf, d);
    `CHK(d, 8'h00)
    repeat (600) @(posedge sys_clk);
    #1 `CHK(fail_safe_q, 1'b0)
    @(posedge sys_clk);
    primary_ready <= 1'b1;
    wr(`CFM_OFF_MASK, 8'h80);
    rd(`CFM_OFF_CLKSEL, d);
    `CHK(d, 8'h08)
    `CHK(dev_clk_sel_q, `CFM_SRC_PRIMARY)
    `CHK(lprc_run_q, 1'b1)
    $display("boot test done");
  endtask
  task t_fail;
    logic [7:0] d;
    wait_fs(1'b1, 1000);
    `CHK(watchdog_clear_q, 1'b1)
    `CHK(dev_clk_sel_q, `CFM_SRC_INTERNAL)
    `CHK(osc_fail_irq_q, 1'b1)
    rd(`CFM_OFF_CLKSEL, d);
    `CHK(d[1:0], `CFM_SRC_PRIMARY)
    rd(`CFM_OFF_FLAG, d);
    `CHK(d, 8'h80)
    wr(`CFM_OFF_FLAG, 8'h80);
    rd(`CFM_OFF_FLAG, d);
    `CHK(d, 8'h00)
    `CHK(osc_fail_irq_q, 1'b0)
    wr(`CFM_OFF_CLKSEL, 8'h70);
    pm_pulse;
    `CHK(fail_safe_q, 1'b0)
    `CHK(dev_clk_sel_q, `CFM_SRC_PRIMARY)
    rd(`CFM_OFF_CLKSEL, d);
    `CHK(d[6:4], 3'h7)
    wait_fs(1'b1, 1000);
    rd(`CFM_OFF_FLAG, d);
    `CHK(d, 8'h80)
    wr(`CFM_OFF_MASK, 8'h00);
    rd(`CFM_OFF_MASK, d);
    `CHK(d, 8'h00)
    `CHK(osc_fail_irq_q, 1'b0)
    pm_pulse;
    $display("failure test done");
  endtask
  task t_quiet;
    @(posedge sys_clk);
    p_run <= 1'b0;
    // A fall just before the stop may still count once
    repeat (300) @(posedge sys_clk);
    pm_pulse;
    repeat (768) @(posedge sys_clk);
    #1 `CHK(fail_safe_q, 1'b0)
    wr(`CFM_OFF_CLKSEL, 8'h02);
    p_run <= 1'b1;
    repeat (768) @(posedge sys_clk);
    #1 `CHK(fail_safe_q, 1'b0)
    wr(`CFM_OFF_CLKSEL, 8'h01);
    wait_fs(1'b1, 1000);
    `CHK(dev_clk_sel_q, `CFM_SRC_INTERNAL)
    pm_pulse;
    `CHK(fail_safe_q, 1'b0)
    `CHK(dev_clk_sel_q, `CFM_SRC_SECONDARY)
    $display("quiet test done");
  endtask
  task t_nofuse;
    logic [7:0] d;
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    monitor_enable_fuse <= 1'b0;
    watchdog_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (768) @(posedge sys_clk);
    #1 `CHK(fail_safe_q, 1'b0)
    `CHK(lprc_run_q, 1'b1)
    @(posedge sys_clk);
    watchdog_enable <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 `CHK(lprc_run_q, 1'b0)
    rd(`CFM_OFF_STAT, d);
    `CHK(d[`CFM_STAT_ENA], 1'b0)
    $display("fuse test done");
  endtask
  initial begin
    {sys_rst, monitor_enable_fuse, watchdog_enable, primary_ready} = 4'hc;
    {pm_mode_entry, reg_we, reg_re, p_run} = 4'h1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_boot;
    t_fail;
    t_quiet;
    t_nofuse;
    complete_run;
  end
endmodule
